/* File: src/host_bus_pkg.sv */
// Constants and carrier types shared by the parallel host port
// ---------------------------------------------------------------
// Behaviour
// - Selected read drives addressed register onto bus
// - DMA read returns receive FIFO, A0/enable size
// - DMA write pushes bus word, address ignored
// - Selected write loads addressed register
// - Data-strobe mode: strobe times, R/W chooses
// - Chip select ignored in acknowledge and DMA
// - Reset level holds device in reset state
// - Powered during reset, powered down after
// - Power-up bit write reactivates its channel
// - Reset floats all outputs, stops oscillator
// - Strobe mode 16-bit: enable marks upper byte
// - Data-strobe mode 16-bit: enable marks lower byte
// - 8-bit bus ignores byte enable pin
// - Width low 8-bit, high 16-bit bus
// - Latch enable level picks mode, latches address
// - Unused data half stays high impedance
// ---------------------------------------------------------------
package host_bus_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int FIFO_W = 19;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Channel power-up bit location
    // ------------------------------------------------------------
    localparam logic [6:0] PWR_ADDR_A = 7'h00;
    localparam logic [6:0] PWR_ADDR_B = 7'h40;
    localparam int PWR_BIT = 4;
    localparam logic [1:0] PWR_RESET = 2'h3;

    // ------------------------------------------------------------
    // Byte lane codes
    // ------------------------------------------------------------
    localparam logic [1:0] LANE_NONE = 2'h0;
    localparam logic [1:0] LANE_LO = 2'h1;
    localparam logic [1:0] LANE_HI = 2'h2;
    localparam logic [1:0] LANE_WORD = 2'h3;

    typedef enum logic [1:0] {
        BUS_STROBE,
        BUS_DSTROBE,
        BUS_MUX
    } bus_mode_t;

    typedef enum logic [2:0] {
        ACC_IDLE,
        ACC_REG_RD,
        ACC_REG_WR,
        ACC_DMA_RD,
        ACC_DMA_WR
    } acc_state_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [15:0] data;
        logic ale;
        logic rd_ds_n;
        logic wr_rw_n;
        logic cs_n;
        logic byte_enable_n;
        logic width;
        logic dma_ack_chan_a_n;
        logic dma_ack_chan_b_n;
        logic irq_ack_n;
    } host_pins_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [15:0] wdata;
        logic [1:0] lanes;
        logic we;
        logic re;
    } reg_req_t;

    typedef struct packed {
        logic chan;
        logic [1:0] lanes;
        logic [15:0] data;
    } tx_word_t;

    // Idle bus levels loaded into the synchroniser on reset, so that
    // the first edges after release do not decode a phantom access
    localparam host_pins_t PINS_IDLE = '{
        addr: 7'h00,
        data: 16'h0000,
        ale: 1'b0,
        rd_ds_n: 1'b1,
        wr_rw_n: 1'b1,
        cs_n: 1'b1,
        byte_enable_n: 1'b1,
        width: 1'b0,
        dma_ack_chan_a_n: 1'b1,
        dma_ack_chan_b_n: 1'b1,
        irq_ack_n: 1'b1
    };

endpackage : host_bus_pkg

/* File: src/host_bus_interface.sv */
// Parallel host port with transmit FIFO and access decoder
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Synchronous FIFO
// ---------------------------------------------------------------
module host_tx_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic not_full;
        logic not_empty;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic do_push;
    logic do_pop;

    assign do_push = in_valid && s.not_full;
    assign do_pop = s.not_empty && out_ready;
    assign in_ready = s.not_full;
    assign out_valid = s.not_empty;
    assign out_data = s.mem[s.rd_ptr];

    always_comb
    begin
        next_s = s;
        if (do_push)
        begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        unique case ({do_push, do_pop})
            2'b10: next_s.count = s.count + 1'b1;
            2'b01: next_s.count = s.count - 1'b1;
            2'b00, 2'b11: next_s.count = s.count;
        endcase
        // Flags are registered so both ports come from flip-flops
        next_s.not_full = next_s.count != FULL_COUNT;
        next_s.not_empty = next_s.count != '0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.not_full <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule : host_tx_fifo

// ---------------------------------------------------------------
// Host bus interface top
// ---------------------------------------------------------------
module host_bus_interface
    import host_bus_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input host_pins_t pins,
    output logic [15:0] data_out,
    output logic [1:0] data_oe,
    output reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] rx_data_a,
    input wire logic [15:0] rx_data_b,
    output logic [1:0] rx_pop,
    output tx_word_t tx_word,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_space,
    output logic [1:0] chan_power_up,
    output logic osc_enable
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] lane_decode(
        input logic wide,
        input logic dstrobe,
        input logic a0,
        input logic be_n
    );
        logic en;
        en = !be_n;
        if (!wide)
        begin
            lane_decode = LANE_LO;
        end
        else if (!dstrobe)
        begin
            unique case ({en, a0})
                2'b10: lane_decode = LANE_WORD;
                2'b11: lane_decode = LANE_HI;
                2'b00: lane_decode = LANE_LO;
                2'b01: lane_decode = LANE_NONE;
            endcase
        end
        else
        begin
            unique case ({en, a0})
                2'b10: lane_decode = LANE_WORD;
                2'b11: lane_decode = LANE_LO;
                2'b00: lane_decode = LANE_HI;
                2'b01: lane_decode = LANE_NONE;
            endcase
        end
    endfunction : lane_decode

    function automatic logic [7:0] lane_byte(
        input logic [15:0] word,
        input logic [1:0] lanes
    );
        lane_byte = (lanes == LANE_HI) ? word[15:8] : word[7:0];
    endfunction : lane_byte

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        host_pins_t sync1;
        host_pins_t sync2;
        logic ale_q;
        logic ale_fell;
        logic [6:0] addr_lat;
        acc_state_t acc;
        logic chan;
        logic [1:0] lanes;
        reg_req_t req;
        logic [15:0] dout;
        logic [1:0] oe;
        logic [1:0] rx_pop;
        tx_word_t tx;
        logic push;
        logic [1:0] power;
        logic live;
        logic osc_en;
        logic space;
    } port_state_t;

    port_state_t s;
    port_state_t next_s;
    host_pins_t p;
    bus_mode_t mode;
    logic dstrobe;
    logic dma;
    logic dma_chan;
    logic rd_act;
    logic wr_act;
    logic sel;
    logic [6:0] addr;
    logic [1:0] lanes_now;
    logic [1:0] lanes_dma_wr;
    logic fifo_ready;
    logic [FIFO_W-1:0] fifo_out;
    logic [7:0] pwr_byte;

    // Only the second synchroniser stage is looked at
    assign p = s.sync2;

    // Once a falling edge is seen the bus is taken as multiplexed
    always_comb
    begin
        if (s.ale_fell)
        begin
            mode = BUS_MUX;
        end
        else if (p.ale)
        begin
            mode = BUS_DSTROBE;
        end
        else
        begin
            mode = BUS_STROBE;
        end
    end

    assign dstrobe = mode == BUS_DSTROBE;
    assign addr = (mode == BUS_MUX) ? s.addr_lat : p.addr;
    assign dma = !p.dma_ack_chan_a_n || !p.dma_ack_chan_b_n;
    assign dma_chan = p.dma_ack_chan_a_n;
    // Data strobe times the cycle, R/W level picks direction
    assign rd_act = dstrobe ? (!p.rd_ds_n && p.wr_rw_n)
                            : !p.rd_ds_n;
    assign wr_act = dstrobe ? (!p.rd_ds_n && !p.wr_rw_n)
                            : !p.wr_rw_n;
    assign sel = !p.cs_n && p.irq_ack_n && !dma;
    assign lanes_now = lane_decode(p.width, dstrobe, addr[0],
                                   p.byte_enable_n);
    assign lanes_dma_wr = lane_decode(p.width, dstrobe, 1'b0,
                                      p.byte_enable_n);
    assign pwr_byte = lane_byte(s.req.wdata, s.req.lanes);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.req.we = 1'b0;
        next_s.req.re = 1'b0;
        next_s.rx_pop = 2'h0;
        next_s.push = s.push && !fifo_ready;
        next_s.space = fifo_ready;
        next_s.live = 1'b1;
        next_s.osc_en = 1'b1;
        // First edge after release powers every channel down
        if (!s.live)
        begin
            next_s.power = 2'h0;
        end

        next_s.ale_q = p.ale;
        if (s.ale_q && !p.ale)
        begin
            next_s.ale_fell = 1'b1;
            next_s.addr_lat = p.addr;
        end

        unique case (s.acc)
            ACC_IDLE:
            begin
                next_s.oe = LANE_NONE;
                if (dma && rd_act)
                begin
                    next_s.acc = ACC_DMA_RD;
                    next_s.chan = dma_chan;
                    next_s.lanes = lanes_now;
                end
                else if (dma && wr_act && !s.push)
                begin
                    next_s.acc = ACC_DMA_WR;
                    next_s.chan = dma_chan;
                    next_s.lanes = lanes_dma_wr;
                end
                else if (sel && rd_act)
                begin
                    next_s.acc = ACC_REG_RD;
                    next_s.lanes = lanes_now;
                    next_s.req.addr = addr;
                    next_s.req.lanes = lanes_now;
                    next_s.req.re = 1'b1;
                end
                else if (sel && wr_act)
                begin
                    next_s.acc = ACC_REG_WR;
                    next_s.lanes = lanes_now;
                    next_s.req.addr = addr;
                    next_s.req.lanes = lanes_now;
                end
            end
            ACC_REG_RD:
            begin
                next_s.dout = reg_rdata;
                next_s.oe = s.lanes;
                if (!rd_act)
                begin
                    next_s.acc = ACC_IDLE;
                    next_s.oe = LANE_NONE;
                end
            end
            ACC_REG_WR:
            begin
                // Data is taken on the last sampled cycle of the strobe
                if (wr_act)
                begin
                    next_s.req.wdata = p.data;
                end
                else
                begin
                    next_s.acc = ACC_IDLE;
                    next_s.req.we = 1'b1;
                    if (s.req.addr == PWR_ADDR_A)
                    begin
                        next_s.power[0] = pwr_byte[PWR_BIT];
                    end
                    if (s.req.addr == PWR_ADDR_B)
                    begin
                        next_s.power[1] = pwr_byte[PWR_BIT];
                    end
                end
            end
            ACC_DMA_RD:
            begin
                next_s.dout = s.chan ? rx_data_b : rx_data_a;
                next_s.oe = s.lanes;
                if (!rd_act)
                begin
                    next_s.acc = ACC_IDLE;
                    next_s.oe = LANE_NONE;
                    next_s.rx_pop[s.chan] = 1'b1;
                end
            end
            ACC_DMA_WR:
            begin
                if (wr_act)
                begin
                    next_s.tx.data = p.data;
                end
                else
                begin
                    next_s.acc = ACC_IDLE;
                    next_s.tx.chan = s.chan;
                    next_s.tx.lanes = s.lanes;
                    next_s.push = 1'b1;
                end
            end
            default:
            begin
                next_s.acc = ACC_IDLE;
                next_s.oe = LANE_NONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.sync1 <= PINS_IDLE;
            s.sync2 <= PINS_IDLE;
            s.power <= PWR_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------
    host_tx_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(s.push),
        .in_ready(fifo_ready),
        .in_data(s.tx),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(fifo_out)
    );

    assign tx_word = tx_word_t'(fifo_out);
    assign data_out = s.dout;
    assign data_oe = s.oe;
    assign reg_req = s.req;
    assign rx_pop = s.rx_pop;
    assign tx_space = s.space;
    assign chan_power_up = s.power;
    assign osc_enable = s.osc_en;

endmodule : host_bus_interface

/* File: verification/host_bus_properties.sv */
// Assertions on the host port outputs
`timescale 1ns/1ps
module host_bus_checker
    import host_bus_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input host_pins_t pins,
    input wire logic [1:0] data_oe,
    input reg_req_t reg_req,
    input wire logic [1:0] rx_pop,
    input wire logic [1:0] chan_power_up,
    input wire logic osc_enable
);
    logic pwr_wr_a;
    logic dack;
    logic access;

    assign pwr_wr_a = reg_req.we && reg_req.addr == PWR_ADDR_A;
    assign dack = !pins.dma_ack_chan_a_n || !pins.dma_ack_chan_b_n;
    assign access = reg_req.re || reg_req.we;

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ----------
    // Properties
    // ----------
    chk_reset_state: assert property (
        $fell(sys_rst) |-> data_oe == 2'h0 && !osc_enable
        && chan_power_up == PWR_RESET ##1 osc_enable && chan_power_up == 2'h0)
        else $error("reset state or release wrong");
    chk_power_cause: assert property (
        $rose(chan_power_up[0]) |-> pwr_wr_a)
        else $error("channel powered up without a write");
    // Pulses of a preceding write land up to three cycles after release
    chk_unselected: assert property (
        (pins.cs_n && !dack && !pins.rd_ds_n) [*3] |-> !reg_req.re)
        else $error("read without chip select");
    chk_ack_blocks: assert property (
        !pins.irq_ack_n [*3] |-> !reg_req.re)
        else $error("read during acknowledge");
    chk_dma_wins: assert property (
        dack [*3] |-> !access)
        else $error("register access during DMA");
    chk_oe_idle: assert property (
        pins.rd_ds_n [*6] |-> data_oe == 2'h0)
        else $error("bus driven without strobe");
    chk_byte_bus: assert property (
        !pins.width [*4] |-> !data_oe[1])
        else $error("upper byte driven on 8-bit bus");
    chk_byte_lanes: assert property (
        !pins.width [*4] ##0 access |-> reg_req.lanes == LANE_LO)
        else $error("8-bit access not on low lane");
    chk_pop_pulse: assert property (
        rx_pop != 2'h0 |-> $onehot(rx_pop) ##1 rx_pop == 2'h0)
        else $error("receive pop not a single pulse");
endmodule : host_bus_checker

bind host_bus_interface host_bus_checker chk (.clk(clk), .sys_rst(sys_rst),
    .pins(pins), .data_oe(data_oe), .reg_req(reg_req), .rx_pop(rx_pop),
    .chan_power_up(chan_power_up), .osc_enable(osc_enable));

/* File: verification/host_model.sv */
// Host processor and DMA master driving the port pins
`timescale 1ns/1ps
module host_model
    import host_bus_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    output host_pins_t pins
);
    // ----------
    // Bus master
    // ----------
    initial
    begin
        pins = '0;
        pins.data = 16'hA5C3;
        pins.rd_ds_n = 1'b1;
        pins.wr_rw_n = 1'b1;
        pins.cs_n = 1'b1;
        pins.byte_enable_n = 1'b1;
        pins.dma_ack_chan_a_n = 1'b1;
        pins.dma_ack_chan_b_n = 1'b1;
        pins.irq_ack_n = 1'b1;
    end

    // Mode level only moves while reset holds the port
    task set_ale(input logic v);
        pins.ale <= v;
    endtask : set_ale

    // k: 0 register, 1 DMA channel A, 2 DMA channel B
    task access(input logic ds, rd, input logic [1:0] k,
        input logic [6:0] a, input logic [15:0] d,
        input logic w, be_n, cs_n, iack_n);
        @(posedge clk);
        pins.addr <= a;
        pins.data <= rd ? ~pins.data : d;
        pins.width <= w;
        pins.byte_enable_n <= w ? be_n : 1'b1;
        pins.cs_n <= cs_n;
        pins.irq_ack_n <= iack_n;
        pins.dma_ack_chan_a_n <= k != 2'h1;
        pins.dma_ack_chan_b_n <= k != 2'h2;
        pins.wr_rw_n <= rd;
        pins.rd_ds_n <= ds ? 1'b0 : !rd;
        repeat (8) @(posedge clk);
        pins.rd_ds_n <= 1'b1;
        pins.wr_rw_n <= 1'b1;
        pins.cs_n <= 1'b1;
        pins.irq_ack_n <= 1'b1;
        pins.dma_ack_chan_a_n <= 1'b1;
        pins.dma_ack_chan_b_n <= 1'b1;
        // A released bus must not keep showing the last word
        pins.data <= ~d;
        repeat (8) @(posedge clk);
    endtask : access
endmodule : host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
module tb_top
    import host_bus_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tx_ready = 1'b0;
    logic [15:0] rx_data_a = 16'h0;
    logic [15:0] rx_data_b = 16'h0;
    host_pins_t pins;
    logic [15:0] data_out, reg_rdata, dout_seen;
    logic [1:0] data_oe, rx_pop, chan_power_up, oe_seen, pop_seen;
    reg_req_t reg_req, last_re, last_we;
    tx_word_t tx_word;
    tx_word_t txq[$];
    logic tx_valid, tx_space, osc_enable;
    logic [31:0] seed = 32'h8C90783B;
    logic [31:0] r;
    int re_cnt, we_cnt, miscompares, samples_checked;

    // ---------------
    // Helpers
    // ---------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [15:0] rdat(input logic [6:0] a);
        return {1'b1, a, 1'b0, ~a};
    endfunction : rdat

    function automatic logic [1:0] lanes(input logic w, ds, a0, be_n);
        if (!w)
            return LANE_LO;
        case ({!be_n, a0})
            2'h2: return LANE_WORD;
            2'h3: return ds ? LANE_LO : LANE_HI;
            2'h0: return ds ? LANE_HI : LANE_LO;
            default: return LANE_NONE;
        endcase
    endfunction : lanes

    function automatic logic [15:0] mask(input logic [1:0] l);
        return {{8{l[1]}}, {8{l[0]}}};
    endfunction : mask

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic op(input logic ds, rd, input logic [1:0] k,
        input logic [6:0] a, input logic [15:0] d,
        input logic w, be_n, cs_n, iack_n);
        logic [1:0] l, eo;
        logic sel;
        logic [15:0] ex;
        l = lanes(w, ds, a[0], be_n);
        sel = k == 2'h0 && !cs_n && iack_n;
        eo = rd && (sel || k != 2'h0) ? l : LANE_NONE;
        @(posedge clk);
        rx_data_a <= 16'(xs());
        rx_data_b <= 16'(xs());
        #1;
        oe_seen = 2'h0;
        pop_seen = 2'h0;
        re_cnt = 0;
        we_cnt = 0;
        host.access(ds, rd, k, a, d, w, be_n, cs_n, iack_n);
        ex = k == 2'h0 ? rdat(a) : k[1] ? rx_data_b : rx_data_a;
        check(oe_seen === eo, "lanes");
        check((dout_seen & mask(eo)) === (ex & mask(eo)), "rdata");
        if (l != LANE_NONE)
        begin
            check(re_cnt == int'(sel && rd), "reads");
            check(we_cnt == int'(sel && !rd), "writes");
            check(pop_seen === (rd ? k : 2'h0), "pops");
            if (sel && rd)
                check(last_re.addr === a
                    && last_re.lanes === l, "rreq");
            if (sel && !rd)
                check(last_we.addr === a && last_we.lanes === l
                    && (last_we.wdata & mask(l)) === (d & mask(l)), "wreq");
        end
    endtask : op

    host_model host (.clk(clk), .sys_rst(sys_rst), .pins(pins));

    host_bus_interface dut (.clk(clk), .sys_rst(sys_rst), .pins(pins),
        .data_out(data_out), .data_oe(data_oe), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .rx_data_a(rx_data_a),
        .rx_data_b(rx_data_b), .rx_pop(rx_pop), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_space(tx_space),
        .chan_power_up(chan_power_up), .osc_enable(osc_enable));

    assign reg_rdata = rdat(reg_req.addr);

    always #2.5 clk = ~clk;

    // ---------------
    // Monitor
    // ---------------
    always @(posedge clk)
    begin
        oe_seen <= oe_seen | data_oe;
        pop_seen <= pop_seen | rx_pop;
        if (data_oe != 2'h0)
            dout_seen <= data_out;
        if (reg_req.re)
            re_cnt <= re_cnt + 1;
        if (reg_req.re)
            last_re <= reg_req;
        if (reg_req.we)
            we_cnt <= we_cnt + 1;
        if (reg_req.we)
            last_we <= reg_req;
        if (tx_valid && tx_ready)
            check(tx_word === txq.pop_front(), "fifo order");
    end

    initial
    begin
        repeat (8) @(posedge clk);
        check(data_oe === 2'h0 && osc_enable === 1'b0, "rst");
        check(chan_power_up === PWR_RESET, "rst power");
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        check(chan_power_up === 2'h0 && osc_enable, "released");
        op(1'h0, 1'h0, 2'h0, PWR_ADDR_A, 16'h1 << PWR_BIT, 1'h0, 1'h1, 1'h0,
            1'h1);
        op(1'h0, 1'h0, 2'h0, PWR_ADDR_B, 16'h1 << PWR_BIT, 1'h1, 1'h0, 1'h0,
            1'h1);
        check(chan_power_up === 2'h3, "power up");
        op(1'h0, 1'h0, 2'h0, PWR_ADDR_A, 16'h0, 1'h0, 1'h1, 1'h0, 1'h1);
        check(chan_power_up === 2'h2, "power down");
        $display("reset and power test done");
        // Unselected and acknowledge reads must stay silent
        op(1'h0, 1'h1, 2'h0, 7'h11, 16'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        op(1'h0, 1'h1, 2'h0, 7'h11, 16'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        for (int i = 0; i < 4; i++)
            op(1'h0, 1'h1, 2'h0, {6'h15, i[0]}, 16'h0, 1'h1, i[1], 1'h0, 1'h1);
        repeat (24)
        begin
            r = xs();
            op(1'h0, r[0], 2'h0, r[7:1], r[23:8], r[24], r[25], r[26] & r[27],
                1'h1);
        end
        $display("register test done");
        for (int i = 0; i < 8; i++)
            op(1'h0, 1'h1, {i[0], !i[0]}, {6'(xs()), i[1]}, 16'h0, 1'h1, i[2],
                1'h0, 1'h1);
        for (int i = 0; i <= FIFO_DEPTH; i++)
        begin
            r = xs();
            op(1'h0, 1'h0, {r[0], !r[0]}, {r[7:2], 1'h0}, r[31:16], 1'h1,
                1'h0, r[1], 1'h1);
            // A write meeting a full FIFO waits and lands once an entry pops
            txq.push_back(tx_word_t'{r[0], LANE_WORD, r[31:16]});
        end
        check(tx_space === 1'b0, "fifo full");
        repeat (100)
        begin
            @(posedge clk);
            tx_ready <= 1'(xs());
        end
        check(txq.size() == 0 && tx_valid === 1'b0, "drained");
        $display("dma test done");
        sys_rst <= 1'b1;
        host.set_ale(1'b1);
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        repeat (12)
        begin
            r = xs();
            op(1'h1, r[0], 2'h0, r[7:1], r[23:8], 1'h1, r[25], 1'h0, 1'h1);
        end
        $display("data strobe test done");
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : tb_top
